// File: verilog/npq_consts.svh
`ifndef NPQ_CONSTS_SVH
`define NPQ_CONSTS_SVH

// Message codes carried in byte 0; the reject code NPQ_RC_INVALID goes in byte 4.
`define NPQ_NODE_QRY     8'h00
`define NPQ_NODE_RPL     8'h01
`define NPQ_PORT_QRY     8'h0a
`define NPQ_PORT_RPL     8'h0b
`define NPQ_GEN_RSP      8'h0f
`define NPQ_RC_INVALID   8'h01

// Reply constants.
`define NPQ_VERSION      8'h02
`define NPQ_PRIO_DEFAULT 3'h4
`define NPQ_CNT_MAX      16'hffff
`define NPQ_PAD_BYTE     8'h00

// Upper-level protocol codes allowed in the node reply.
`define NPQ_ULP_ASK      8'h00
`define NPQ_ULP_NONE     8'h01
`define NPQ_ULP_VENDOR   8'h02
`define NPQ_ULP_SP       8'h80
`define NPQ_ULP_S2P      8'h82
`define NPQ_ULP_S3P      8'h83

// Frame lengths in bytes.
`define NPQ_NODE_QRY_LEN 5'h08
`define NPQ_PORT_QRY_LEN 5'h09
`define NPQ_NODE_RPL_LEN 5'h15
`define NPQ_PORT_RPL_LEN 5'h10
`define NPQ_GEN_RSP_LEN  5'h05

// Field positions.
`define NPQ_B5_FULL      7
`define NPQ_B20_P1       7
`define NPQ_B20_P2       6
`define NPQ_B8_OPT       7
`define NPQ_B8_LOOP      6
`define NPQ_B8_CLR       0

// Controller register offsets.
`define NPQ_REG_CTRL     8'h00
`define NPQ_REG_QUERY    8'h04
`define NPQ_REG_PATH     8'h08
`define NPQ_REG_STATUS   8'h0c
`define NPQ_REG_RPID     8'h10
`define NPQ_REG_REPLY    8'h20
`define NPQ_REG_REPLY_N  6

// AXI response codes.
`define NPQ_RESP_OKAY    2'h0
`define NPQ_RESP_SLVERR  2'h2

`endif

// File: verilog/npq_pkg.sv
package npq_pkg;
  typedef enum logic [2:0] {
    NPQ_D_IDLE  = 3'h0,
    NPQ_D_RX    = 3'h1,
    NPQ_D_BUILD = 3'h2,
    NPQ_D_TX    = 3'h3,
    NPQ_D_DONE  = 3'h4
  } npq_dev_e;

  typedef enum logic [1:0] {
    NPQ_H_IDLE = 2'h0,
    NPQ_H_SEND = 2'h1,
    NPQ_H_WAIT = 2'h2
  } npq_host_e;

  typedef logic [7:0] npq_byte_t;
endpackage

// File: verilog/npq_link_if.sv
`timescale 1ns/1ps
// Byte-wide query and reply channels between configuring node and device.
interface npq_link_if;
  logic        q_valid;
  logic [7:0]  q_data;
  logic        q_last;
  logic [7:0]  q_port;
  logic        r_valid;
  logic [7:0]  r_data;
  logic        r_last;
  logic [7:0]  r_port;
  logic [31:0] r_path;
  logic [2:0]  r_path_len;

  modport dev (input q_valid, q_data, q_last, q_port,
               output r_valid, r_data, r_last, r_port, r_path, r_path_len);
  modport host (output q_valid, q_data, q_last, q_port,
                input r_valid, r_data, r_last, r_port, r_path, r_path_len);
endinterface

// File: verilog/npq_device.sv
`timescale 1ns/1ps
`include "npq_consts.svh"
module npq_device #(
  parameter int          NPORTS     = 2,
  parameter int          TBL_DEPTH  = 4,
  parameter logic [7:0]  ULP_CODE   = `NPQ_ULP_ASK,
  parameter logic [2:0]  MASTER_PRI = `NPQ_PRIO_DEFAULT,
  parameter logic [63:0] UNIQUE_ID  = 64'h0011_2233_4455_6677, // Arbitrary.
  parameter logic [31:0] RPID_SEED  = 32'h0000_0001
) (
  input  wire logic                     clock,           // 25 MHz clock
  input  wire logic                     rst_b,           // Async reset
  npq_link_if.dev                       link,            // Query link
  input  wire logic [NPORTS-1:0]        port_oper,       // Port operational
  input  wire logic [NPORTS-1:0]        recov_evt,       // Recovery pulse
  input  wire logic                     reset_frame,     // Reset frame seen
  input  wire logic                     table_clear,     // Empty peer table
  input  wire logic                     loopback_flag,   // Node loopback_flag flag
  input  wire logic [NPORTS-1:0][7:0]   a_quota,         // Frame A quota
  input  wire logic [NPORTS-1:0][7:0]   b_quota,         // Frame B quota
  input  wire logic [NPORTS-1:0]        port_option_bit, // Port option
  input  wire logic [NPORTS-1:0][1:0]   port_mode,       // Port mode
  input  wire logic [NPORTS-1:0][15:0]  alarm_thresh,    // Alarm threshold
  output logic [NPORTS-1:0][15:0]       link_recovery_counter, // Counts
  output logic                          peer_table_full, // Last node query found table full
  output logic                          busy             // Query in hand
);
  import npq_pkg::*;

  // Port count must be one, two, or an even switch count up to 126.
  if (NPORTS < 1 || NPORTS > 126 || (NPORTS > 2 && NPORTS % 2 != 0)) begin
    $error("npq_device: unsupported port count");
  end
  if (!(ULP_CODE == `NPQ_ULP_ASK || ULP_CODE == `NPQ_ULP_NONE ||
        ULP_CODE == `NPQ_ULP_VENDOR || ULP_CODE == `NPQ_ULP_SP ||
        ULP_CODE == `NPQ_ULP_S2P || ULP_CODE == `NPQ_ULP_S3P)) begin
    $error("npq_device: protocol code not legal in node reply");
  end
  if (TBL_DEPTH < 1 || TBL_DEPTH > 255) begin
    $error("npq_device: table depth out of range");
  end

  typedef struct packed {
    npq_dev_e                 phase;
    logic [8:0][7:0]          rxb;
    logic [3:0]               rxn;
    logic [7:0]               port;
    logic [20:0][7:0]         txb;
    logic [4:0]               txn;
    logic [4:0]               txi;
    logic                     clr;
    logic [7:0]               clr_port;
    logic [NPORTS-1:0][15:0]  cnt;
    logic [7:0]               tbl;
    logic [31:0]              rpid;
    logic                     full;
    logic                     busy;
    logic                     r_valid;
    logic                     r_last;
    logic [7:0]               r_data;
    logic [31:0]              r_path;
    logic [2:0]               r_path_len;
  } npq_dev_s;

  npq_dev_s s_r;
  npq_dev_s s_nxt;

  localparam logic [7:0] TBL_MAX   = 8'(TBL_DEPTH);
  localparam logic [7:0] OTHER_CNT = 8'(NPORTS - 1);
  localparam logic [7:0] PORT_MAX  = 8'(NPORTS);

  // Path length stops at the first pad byte; later bytes are padding.
  function automatic logic [2:0] path_len(input logic [31:0] p);
    logic [2:0] n;
    logic       stop;
    n = 3'h0;
    stop = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (!stop && p[31-8*k -: 8] != `NPQ_PAD_BYTE) begin
        n = n + 3'h1;
      end else begin
        stop = 1'b1;
      end
    end
    return n;
  endfunction

  assign link.r_valid           = s_r.r_valid;
  assign link.r_data            = s_r.r_data;
  assign link.r_last            = s_r.r_last;
  assign link.r_port            = s_r.port;
  assign link.r_path            = s_r.r_path;
  assign link.r_path_len        = s_r.r_path_len;
  assign link_recovery_counter  = s_r.cnt;
  assign peer_table_full        = s_r.full;
  assign busy                   = s_r.busy;

  // Next state: receive, build, transmit, then apply deferred clears.
  always_comb begin
    int         pi;
    logic       pvalid;
    logic [7:0] code;
    s_nxt = s_r;
    pi = 0;
    pvalid = 1'b0;
    code = s_r.rxb[0];
    if (table_clear) begin
      s_nxt.tbl = 8'h00;
    end
    // Counter clear is deferred to DONE so the reply carries the old value.
    for (int p = 0; p < NPORTS; p++) begin
      if (reset_frame) begin
        s_nxt.cnt[p] = 16'h0000;
      end else if (s_r.phase == NPQ_D_DONE && s_r.clr &&
                   s_r.clr_port == 8'(p + 1)) begin
        s_nxt.cnt[p] = 16'h0000;
      end
      // An event in the clearing cycle still counts.
      if (recov_evt[p] && s_nxt.cnt[p] != `NPQ_CNT_MAX) begin
        s_nxt.cnt[p] = s_nxt.cnt[p] + 16'h0001;
      end
    end
    pvalid = (s_r.rxn == 4'(`NPQ_PORT_QRY_LEN)) &&
             (s_r.rxb[1] >= 8'h01) && (s_r.rxb[1] <= PORT_MAX) &&
             (s_r.rxb[8][7:1] == 7'h00);
    if (pvalid) begin
      pi = int'(s_r.rxb[1]) - 1;
    end
    case (s_r.phase)
      NPQ_D_IDLE: begin
        s_nxt.r_valid = 1'b0;
        s_nxt.r_last = 1'b0;
        if (link.q_valid) begin
          s_nxt.rxb = '0;
          s_nxt.rxb[0] = link.q_data;
          s_nxt.rxn = 4'h1;
          s_nxt.port = link.q_port;
          s_nxt.phase = link.q_last ? NPQ_D_BUILD : NPQ_D_RX;
        end
      end
      NPQ_D_RX: begin
        if (link.q_valid) begin
          if (s_r.rxn < 4'h9) begin
            s_nxt.rxb[s_r.rxn] = link.q_data;
          end
          // Saturate at ten so an overlong frame stays invalid.
          if (s_r.rxn < 4'ha) begin
            s_nxt.rxn = s_r.rxn + 4'h1;
          end
          if (link.q_last) begin
            s_nxt.phase = NPQ_D_BUILD;
          end
        end
      end
      NPQ_D_BUILD: begin
        s_nxt.txb = '0;
        s_nxt.txi = 5'h00;
        s_nxt.clr = 1'b0;
        s_nxt.phase = NPQ_D_TX;
        s_nxt.r_path = {s_r.rxb[4], s_r.rxb[5], s_r.rxb[6], s_r.rxb[7]};
        s_nxt.r_path_len = path_len(s_nxt.r_path);
        s_nxt.txb[2] = s_r.rxb[2];
        s_nxt.txb[3] = s_r.rxb[3];
        if (code == `NPQ_NODE_QRY) begin
          s_nxt.txn = `NPQ_NODE_RPL_LEN;
          s_nxt.txb[0] = `NPQ_NODE_RPL;
          s_nxt.txb[1] = s_r.port;
          s_nxt.txb[4] = ULP_CODE;
          s_nxt.full = (s_r.tbl >= TBL_MAX);
          s_nxt.txb[5][`NPQ_B5_FULL] = s_nxt.full;
          if (!s_nxt.full) begin
            s_nxt.tbl = s_r.tbl + 8'h01;
          end
          s_nxt.txb[5][6:4] = MASTER_PRI;
          s_nxt.txb[6] = OTHER_CNT;
          s_nxt.txb[7] = `NPQ_VERSION;
          for (int k = 0; k < 8; k++) begin
            s_nxt.txb[8+k] = UNIQUE_ID[63-8*k -: 8];
          end
          for (int k = 0; k < 4; k++) begin
            s_nxt.txb[16+k] = s_r.rpid[31-8*k -: 8];
          end
          s_nxt.rpid = s_r.rpid + 32'h0000_0001;
          if (NPORTS <= 2) begin
            s_nxt.txb[20][`NPQ_B20_P1] = port_oper[0];
          end
          if (NPORTS == 2) begin
            s_nxt.txb[20][`NPQ_B20_P2] = port_oper[NPORTS-1];
          end
        end else if (code == `NPQ_PORT_QRY && pvalid) begin
          s_nxt.txn = `NPQ_PORT_RPL_LEN;
          s_nxt.txb[0] = `NPQ_PORT_RPL;
          s_nxt.txb[4] = s_r.cnt[pi][15:8];
          s_nxt.txb[5] = s_r.cnt[pi][7:0];
          s_nxt.txb[6] = a_quota[pi];
          s_nxt.txb[7] = b_quota[pi];
          s_nxt.txb[8][`NPQ_B8_OPT] = port_option_bit[pi];
          s_nxt.txb[8][`NPQ_B8_LOOP] = loopback_flag;
          s_nxt.txb[8][5:4] = port_mode[pi];
          s_nxt.txb[10] = alarm_thresh[pi][15:8];
          s_nxt.txb[11] = alarm_thresh[pi][7:0];
          s_nxt.txb[13] = 8'h01;
          s_nxt.txb[15] = {7'h00, port_oper[pi]};
          s_nxt.clr = s_r.rxb[8][`NPQ_B8_CLR];
          s_nxt.clr_port = s_r.rxb[1];
        end else if (code == `NPQ_PORT_QRY) begin
          s_nxt.txn = `NPQ_GEN_RSP_LEN;
          s_nxt.txb[0] = `NPQ_GEN_RSP;
          s_nxt.txb[4] = `NPQ_RC_INVALID;
        end else begin
          // Other queries belong to other blocks; drop them silently.
          s_nxt.phase = NPQ_D_IDLE;
        end
      end
      NPQ_D_TX: begin
        s_nxt.r_valid = 1'b1;
        s_nxt.r_data = s_r.txb[s_r.txi];
        s_nxt.r_last = (s_r.txi == s_r.txn - 5'h01);
        s_nxt.txi = s_r.txi + 5'h01;
        if (s_nxt.r_last) begin
          s_nxt.phase = NPQ_D_DONE;
        end
      end
      NPQ_D_DONE: begin
        s_nxt.r_valid = 1'b0;
        s_nxt.r_last = 1'b0;
        s_nxt.clr = 1'b0;
        s_nxt.phase = NPQ_D_IDLE;
      end
      default: begin
        s_nxt.phase = NPQ_D_IDLE;
      end
    endcase
    s_nxt.busy = (s_nxt.phase != NPQ_D_IDLE);
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.rpid <= RPID_SEED;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// File: verilog/npq_host.sv
`timescale 1ns/1ps
`include "npq_consts.svh"
module npq_host (
  input  wire logic        clock,     // 25 MHz clock
  input  wire logic        rst_b,     // Async reset
  npq_link_if.host         link,      // Query link
  input  wire logic [7:0]  s_awaddr,  // Write address
  input  wire logic        s_awvalid, // Write address valid
  output logic             s_awready, // Write address ready
  input  wire logic [31:0] s_wdata,   // Write data
  input  wire logic [3:0]  s_wstrb,   // Byte strobes
  input  wire logic        s_wvalid,  // Write data valid
  output logic             s_wready,  // Write data ready
  output logic [1:0]       s_bresp,   // Write response
  output logic             s_bvalid,  // Write response valid
  input  wire logic        s_bready,  // Write response ready
  input  wire logic [7:0]  s_araddr,  // Read address
  input  wire logic        s_arvalid, // Read address valid
  output logic             s_arready, // Read address ready
  output logic [31:0]      s_rdata,   // Read data
  output logic [1:0]       s_rresp,   // Read response
  output logic             s_rvalid,  // Read data valid
  input  wire logic        s_rready   // Read data ready
);
  import npq_pkg::*;

  typedef struct packed {
    npq_host_e        phase;
    logic [2:0]       ctrl;
    logic [31:0]      query;
    logic [31:0]      path;
    logic [8:0][7:0]  txb;
    logic [3:0]       txn;
    logic [3:0]       txi;
    logic [23:0][7:0] rxb;
    logic [4:0]       rxn;
    logic             done;
    logic             sw_need;
    logic             tag_bad;
    logic [31:0]      rpid;
    logic             q_valid;
    logic             q_last;
    logic [7:0]       q_data;
    logic             awready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } npq_host_s;

  npq_host_s h_r;
  npq_host_s h_nxt;

  assign link.q_valid = h_r.q_valid;
  assign link.q_data  = h_r.q_data;
  assign link.q_last  = h_r.q_last;
  assign link.q_port  = h_r.query[31:24];
  assign s_awready    = h_r.awready;
  assign s_wready     = h_r.awready;
  assign s_bvalid     = h_r.bvalid;
  assign s_bresp      = h_r.bresp;
  assign s_arready    = h_r.arready;
  assign s_rvalid     = h_r.rvalid;
  assign s_rdata      = h_r.rdata;
  assign s_rresp      = h_r.rresp;

  // Register slave, query sender and reply collector in one pass.
  always_comb begin
    int   w;
    logic go;
    h_nxt = h_r;
    w = 0;
    go = 1'b0;
    h_nxt.awready = 1'b0;
    h_nxt.arready = 1'b0;
    if (h_r.bvalid && s_bready) begin
      h_nxt.bvalid = 1'b0;
    end
    if (h_r.awready) begin
      h_nxt.bvalid = 1'b1;
      h_nxt.bresp = `NPQ_RESP_OKAY;
      case (s_awaddr)
        `NPQ_REG_CTRL: begin
          h_nxt.ctrl = s_wdata[2:0];
          go = s_wdata[0];
        end
        `NPQ_REG_QUERY: h_nxt.query = s_wdata;
        `NPQ_REG_PATH:  h_nxt.path = s_wdata;
        default:        h_nxt.bresp = `NPQ_RESP_SLVERR;
      endcase
    end else if (s_awvalid && s_wvalid && !h_r.bvalid) begin
      h_nxt.awready = 1'b1;
    end
    if (h_r.rvalid && s_rready) begin
      h_nxt.rvalid = 1'b0;
    end
    if (h_r.arready) begin
      h_nxt.rvalid = 1'b1;
      h_nxt.rresp = `NPQ_RESP_OKAY;
      h_nxt.rdata = 32'h0000_0000;
      w = int'(s_araddr[7:2]) - int'(`NPQ_REG_REPLY >> 2);
      case (s_araddr)
        `NPQ_REG_CTRL:   h_nxt.rdata = {29'h0, h_r.ctrl};
        `NPQ_REG_QUERY:  h_nxt.rdata = h_r.query;
        `NPQ_REG_PATH:   h_nxt.rdata = h_r.path;
        `NPQ_REG_STATUS: h_nxt.rdata = {11'h0, h_r.rxn, h_r.rxb[0],
                                        4'h0, h_r.tag_bad, h_r.sw_need,
                                        h_r.done,
                                        h_r.phase != NPQ_H_IDLE};
        `NPQ_REG_RPID:   h_nxt.rdata = h_r.rpid;
        default: begin
          if (s_araddr[1:0] == 2'h0 && w >= 0 && w < `NPQ_REG_REPLY_N) begin
            h_nxt.rdata = {h_r.rxb[4*w], h_r.rxb[4*w+1],
                           h_r.rxb[4*w+2], h_r.rxb[4*w+3]};
          end else begin
            h_nxt.rresp = `NPQ_RESP_SLVERR;
          end
        end
      endcase
    end else if (s_arvalid && !h_r.rvalid) begin
      h_nxt.arready = 1'b1;
    end
    case (h_r.phase)
      NPQ_H_IDLE: begin
        h_nxt.q_valid = 1'b0;
        h_nxt.q_last = 1'b0;
        // One query outstanding at a time keeps every live tag unique.
        if (go) begin
          h_nxt.txb = '0;
          h_nxt.txb[0] = h_nxt.ctrl[1] ? `NPQ_PORT_QRY : `NPQ_NODE_QRY;
          h_nxt.txb[1] = h_nxt.ctrl[1] ? h_nxt.query[7:0] : 8'h00;
          h_nxt.txb[2] = h_nxt.query[23:16];
          h_nxt.txb[3] = h_nxt.query[15:8];
          for (int k = 0; k < 4; k++) begin
            h_nxt.txb[4+k] = h_nxt.path[31-8*k -: 8];
          end
          h_nxt.txb[8] = {7'h00, h_nxt.ctrl[2]};
          h_nxt.txn = h_nxt.ctrl[1] ? 4'(`NPQ_PORT_QRY_LEN)
                                    : 4'(`NPQ_NODE_QRY_LEN);
          h_nxt.txi = 4'h0;
          h_nxt.rxn = 5'h00;
          h_nxt.done = 1'b0;
          h_nxt.phase = NPQ_H_SEND;
        end
      end
      NPQ_H_SEND: begin
        h_nxt.q_valid = 1'b1;
        h_nxt.q_data = h_r.txb[h_r.txi];
        h_nxt.q_last = (h_r.txi == h_r.txn - 4'h1);
        h_nxt.txi = h_r.txi + 4'h1;
        if (h_nxt.q_last) begin
          h_nxt.phase = NPQ_H_WAIT;
        end
      end
      NPQ_H_WAIT: begin
        h_nxt.q_valid = 1'b0;
        h_nxt.q_last = 1'b0;
        if (link.r_valid) begin
          if (h_r.rxn < 5'(`NPQ_REG_REPLY_N * 4)) begin
            h_nxt.rxb[h_r.rxn] = link.r_data;
            h_nxt.rxn = h_r.rxn + 5'h01;
          end
          if (link.r_last) begin
            h_nxt.done = 1'b1;
            h_nxt.phase = NPQ_H_IDLE;
            h_nxt.tag_bad = (h_nxt.rxb[2] != h_r.query[23:16]) ||
                            (h_nxt.rxb[3] != h_r.query[15:8]);
            if (h_nxt.rxb[0] == `NPQ_NODE_RPL) begin
              h_nxt.rpid = {h_nxt.rxb[16], h_nxt.rxb[17],
                            h_nxt.rxb[18], h_nxt.rxb[19]};
              h_nxt.sw_need = (h_nxt.rxb[6] > 8'h02);
            end
          end
        end
      end
      default: begin
        h_nxt.phase = NPQ_H_IDLE;
      end
    endcase
  end

  // Single state register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end
endmodule

// File: verif/npq_props.sv
`timescale 1ns/1ps
module npq_props (
  input wire logic        clock,     // Clock
  input wire logic        rst_b,     // Async reset
  input wire logic        q_valid,   // Query valid
  input wire logic [7:0]  q_data,    // Query byte
  input wire logic        q_last,    // Query end
  input wire logic [7:0]  q_port,    // Arrival port
  input wire logic        r_valid,   // Reply valid
  input wire logic [7:0]  r_data,    // Reply byte
  input wire logic        r_last,    // Reply end
  input wire logic [7:0]  r_port,    // Leaving port
  input wire logic [31:0] r_path,    // Reply path
  input wire logic [2:0]  r_path_len // Path bytes
);
  logic [4:0]  qc_r;
  logic [4:0]  rc_r;
  logic [7:0]  code_r;
  logic [15:0] tag_r;
  logic [31:0] path_r;
  logic [2:0]  plen;
  // Byte positions let each check name the field that it looks at.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      qc_r <= 5'h0;
      rc_r <= 5'h0;
      code_r <= 8'h0;
      tag_r <= 16'h0;
      path_r <= 32'h0;
    end else begin
      if (q_valid) qc_r <= q_last ? 5'h0 : qc_r + 5'h1;
      if (q_valid && qc_r == 5'h2) tag_r[15:8] <= q_data;
      if (q_valid && qc_r == 5'h3) tag_r[7:0] <= q_data;
      if (q_valid && qc_r[4:2] == 3'h1) path_r <= {path_r[23:0], q_data};
      if (r_valid) rc_r <= r_last ? 5'h0 : rc_r + 5'h1;
      if (r_valid && rc_r == 5'h0) code_r <= r_data;
    end
  end
  // Path length stops at the first padding byte.
  assign plen = (path_r[31:24] == 8'h0) ? 3'h0 :
                (path_r[23:16] == 8'h0) ? 3'h1 :
                (path_r[15:8] == 8'h0) ? 3'h2 :
                (path_r[7:0] == 8'h0) ? 3'h3 : 3'h4;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_reply_delay: assert property (q_valid && q_last |-> ##3 r_valid)
    else $error("reply did not start three cycles after query");
  a_code_legal: assert property (r_valid && rc_r == 5'h0 |->
    r_data inside {8'h01, 8'h0b, 8'h0f}) else $error("bad reply code");
  a_node_len: assert property (r_valid && rc_r == 5'h0 &&
    r_data == 8'h01 |-> ##20 r_last) else $error("node reply length");
  a_port_len: assert property (r_valid && rc_r == 5'h0 &&
    r_data == 8'h0b |-> ##15 r_last) else $error("port reply length");
  a_tag_echo: assert property (r_valid && rc_r == 5'h2 |->
    r_data == tag_r[15:8] ##1 r_data == tag_r[7:0]) else $error("tag");
  a_port_field: assert property (r_valid && rc_r == 5'h1 &&
    code_r == 8'h01 |-> r_data == r_port) else $error("port field");
  a_same_port: assert property (r_valid |-> r_port == q_port)
    else $error("reply port differs from arrival port");
  a_reply_path: assert property (r_valid |-> r_path == path_r &&
    r_path_len == plen) else $error("reply path wrong");
  a_speed_word: assert property (r_valid && rc_r == 5'hd &&
    code_r == 8'h0b |-> r_data == 8'h01 && $past(r_data) == 8'h00)
    else $error("supported speed word wrong");
  a_reserved_zero: assert property (r_valid && code_r == 8'h0b &&
    rc_r inside {5'h1, 5'h9, 5'he} |-> r_data == 8'h00)
    else $error("reserved byte not zero");
  a_last_pulse: assert property (r_last |-> r_valid ##1 !r_valid)
    else $error("reply end not a single byte");
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
`include "npq_consts.svh"
module tb;
  localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef; // Arbitrary.
  logic clock = 1'b0, rst_b = 1'b0, reset_frame = 1'b0, table_clear = 1'b0;
  logic [1:0] port_oper = 2'h0, recov_evt = 2'h0, port_option_bit = 2'h0;
  logic loopback_flag = 1'b0, peer_table_full, busy;
  logic [1:0][7:0]  a_quota = '0, b_quota = '0;
  logic [1:0][1:0]  port_mode = '0;
  logic [1:0][15:0] alarm_thresh = '0, link_recovery_counter;
  logic [7:0]  s_awaddr = 8'h0, s_araddr = 8'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata, s;
  logic [3:0]  s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]   s_bresp, s_rresp, r;
  logic [191:0] got, exv;
  logic [15:0]  cnt [2];
  int           failures = 0, comparisons = 0, seed = 32'hbf9f5848, k, m;

  npq_link_if link ();
  npq_device #(.TBL_DEPTH(2), .UNIQUE_ID(UID), .RPID_SEED(32'h10))
    npq_device_inst (.clock, .rst_b, .link, .port_oper, .recov_evt,
    .reset_frame, .table_clear, .loopback_flag, .a_quota, .b_quota,
    .port_option_bit, .port_mode, .alarm_thresh, .link_recovery_counter,
    .peer_table_full, .busy);
  npq_host npq_host_inst (.clock, .rst_b, .link, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready);
  npq_props npq_props_inst (.clock(clock), .rst_b(rst_b),
    .q_valid(link.q_valid), .q_data(link.q_data), .q_last(link.q_last),
    .q_port(link.q_port), .r_valid(link.r_valid), .r_data(link.r_data),
    .r_last(link.r_last), .r_port(link.r_port), .r_path(link.r_path),
    .r_path_len(link.r_path_len));

  // Free-running 25 MHz clock.
  initial forever #20 clock = ~clock;

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // A wait that runs dry counts as a mismatch and ends the run.
  task automatic tmo;
    failures++;
    $display("wrong value at %0t: wait ran out", $time);
    wrap_up();
  endtask

  // Address and data are offered together and each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_awready) {s_awvalid, s_wvalid} <= 2'h0;
      if (s_bvalid) break;
    end
    if (n == 50) tmo();
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    @(posedge clock);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    if (n == 50) tmo();
    d = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask

  // One query via the host; c is {clear, kind, go}. e5 and id only matter
  // for the node reply, where they give byte 5 and the path identifier.
  task automatic query(input logic [2:0] c, input logic [7:0] p,
                       input logic [7:0] e5, input logic [31:0] id);
    logic [15:0] tg;
    logic [31:0] pa;
    logic [7:0]  lp;
    int          i, n, j;
    tg = 16'($random(seed));
    pa = $random(seed);
    lp = 8'($random(seed));
    i = p[1] ? 1 : 0;
    if (pa[0]) pa[15:0] = 16'h0;
    wr(`NPQ_REG_PATH, pa);
    wr(`NPQ_REG_QUERY, {lp, tg, p});
    wr(`NPQ_REG_CTRL, {29'h0, c});
    repeat (2) @(posedge clock);
    chk(busy, 1'b1);
    s = 32'h0;
    for (n = 0; n < 40 && !s[1]; n++) rd(`NPQ_REG_STATUS, s, r);
    if (!s[1]) tmo();
    chk(s[3:2], 2'h0);
    for (n = 0; n < 6; n++) rd(`NPQ_REG_REPLY + 8'(4 * n), got[191-32*n -: 32], r);
    if (!c[1]) begin
      rd(`NPQ_REG_RPID, s, r);
      chk(s, id);
      n = 21;
      exv = {8'h01, lp, tg, 8'h00, e5, 8'h01, 8'h02, UID, id, port_oper[0],
             port_oper[1], 30'h0};
    end else if (p == 8'h0 || p > 8'h2) begin
      n = 5;
      exv = {8'h0f, 8'h00, tg, 8'h01, 152'h0};
    end else begin
      n = 16;
      exv = {8'h0b, 8'h00, tg, cnt[i], a_quota[i], b_quota[i],
             port_option_bit[i], loopback_flag, port_mode[i], 4'h0, 8'h00,
             alarm_thresh[i], 16'h0001, 15'h0, port_oper[i], 64'h0};
    end
    for (j = 0; j < n; j++) chk(got[191-8*j -: 8], exv[191-8*j -: 8]);
    if (n == 16 && c[2]) begin
      cnt[i] = 16'h0;
      chk(link_recovery_counter[i], 16'h0);
    end
  endtask

  initial begin
    cnt[0] = 16'h0;
    cnt[1] = 16'h0;
    s = 32'h0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    port_oper <= 2'($random(seed));
    // Two table slots: the third node query finds it full, a clear frees it.
    for (k = 0; k < 4; k++) begin
      if (k == 3) begin
        table_clear <= 1'b1;
        @(posedge clock);
        table_clear <= 1'b0;
      end
      query(3'h1, 8'h0, (k == 2) ? 8'hc0 : 8'h40, 32'h10 + k);
      chk(peer_table_full, k == 2);
    end
    $display("node query test done");
    // Random settings, recovery events and clear flags on both ports.
    for (k = 0; k < 10; k++) begin
      {a_quota, b_quota} <= $random(seed);
      alarm_thresh <= $random(seed);
      {port_option_bit, port_mode, loopback_flag, port_oper} <= 9'($random(seed));
      m = 1 + ($random(seed) & 1);
      repeat (k) begin
        @(posedge clock);
        recov_evt <= 2'(m);
        @(posedge clock);
        recov_evt <= 2'h0;
      end
      cnt[m-1] += 16'(k);
      query({1'($random(seed)), 2'h3}, 8'(m), 8'h0, 32'h0);
    end
    $display("port query test done");
    query(3'h3, 8'h0, 8'h0, 32'h0);
    query(3'h7, 8'h3, 8'h0, 32'h0);
    rd(8'h80, s, r);
    chk(r, `NPQ_RESP_SLVERR);
    wr(8'h80, 32'h0);
    chk(s_bresp, `NPQ_RESP_SLVERR);
    $display("refusal test done");
    // Hold events past the counter's ceiling, then a reset frame.
    recov_evt <= 2'h2;
    repeat (65540) @(posedge clock);
    recov_evt <= 2'h0;
    cnt[1] = 16'hffff;
    query(3'h3, 8'h2, 8'h0, 32'h0);
    reset_frame <= 1'b1;
    @(posedge clock);
    reset_frame <= 1'b0;
    repeat (2) @(posedge clock);
    chk(link_recovery_counter, 32'h0);
    $display("saturation test done");
    wrap_up();
  end
endmodule
